//--- ocl_params.svh
`ifndef OCL_PARAMS_SVH
`define OCL_PARAMS_SVH

// ============================================================
// Register byte offsets.
`define OCL_ADDR_MP      12'h000
`define OCL_ADDR_EXT     12'h004
`define OCL_ADDR_INT     12'h008
`define OCL_ADDR_ULP     12'h00C
`define OCL_ADDR_STATUS  12'h010
`define OCL_ADDR_IE_SET  12'h014
`define OCL_ADDR_IE_CLR  12'h018
`define OCL_ADDR_FLAG    12'h01C

// ============================================================
// Field positions shared by the oscillator control words.
`define OCL_F_EN         1
`define OCL_F_XTAL       2
`define OCL_F_O32        3
`define OCL_F_O1         4
`define OCL_F_SR         6
`define OCL_F_OD         7
`define OCL_F_GAIN_LO    8
`define OCL_F_GAIN_HI    10
`define OCL_F_AMP        11
`define OCL_F_MST_LO     12
`define OCL_F_MST_HI     15
`define OCL_F_XST_LO     8
`define OCL_F_XST_HI     10
`define OCL_F_ITR_LO     16
`define OCL_F_ITR_HI     22
`define OCL_F_UTR_LO     0
`define OCL_F_UTR_HI     4

// ============================================================
// Status, enable and flag bit positions.
`define OCL_B_MP         0
`define OCL_B_EXT        1
`define OCL_B_INT        2

// ============================================================
// Reset values and timing.
`define OCL_RST_OD       1'b1
`define OCL_RST_TRIM     7'h00
`define OCL_INT_START_CYC 16'h0040
`define OCL_CNT_FULL     16'hFFFF
`define OCL_SEL_FULL     4'hF

`endif

//--- ocl_pin_model.sv
`timescale 1ns/100ps
// ============================================================
// Crystal and board wiring on the multipurpose oscillator pins.
module ocl_pin_model (
   // Clock.
   input  wire logic clk,
   // Pin ownership from the block.
   input  wire logic in_ovr,
   input  wire logic out_ovr,
   // Board side.
   input  wire logic gpio_out,
   output logic      pin_out
);
   logic xtal_q = 1'b0;

   // The crystal swings only while the input pin is given to it.
   always_ff @(posedge clk) begin
      xtal_q <= in_ovr ? !xtal_q : 1'b0;
   end

   // An owned pin carries the crystal, a free pin carries the port pin.
   assign pin_out = out_ovr ? xtal_q : gpio_out;
endmodule : ocl_pin_model

//--- ocl_pkg.sv
package ocl_pkg;

   // Sleep mode presented by the power manager, Gray coded.
   typedef enum logic [1:0] {
      OCL_ACTIVE  = 2'b00,
      OCL_IDLE    = 2'b01,
      OCL_STANDBY = 2'b11
   } ocl_sleep_t;

   // State cleared by any reset.
   typedef struct packed {
      logic        mp_en;
      logic        mp_xtal;
      logic        mp_sr;
      logic        mp_od;
      logic [2:0]  mp_gain;
      logic        mp_amp;
      logic [3:0]  mp_start;
      logic [15:0] mp_cnt;
      logic        mp_rdy;
      logic        mp_run;
      logic        mp_in_ovr;
      logic        mp_out_ovr;
      logic        mp_clk_ok;
      logic        int_en;
      logic        int_o32;
      logic        int_o1;
      logic        int_sr;
      logic        int_od;
      logic [6:0]  int_trim;
      logic [6:0]  int_trim_act;
      logic [15:0] int_cnt;
      logic        int_rdy;
      logic        int_run;
      logic        int_o32_q;
      logic        int_o1_q;
      logic [4:0]  ulp_trim;
      logic        trim_load;
      logic        ext_rdy_prev;
      logic [2:0]  ie;
      logic [2:0]  flag;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ocl_state_t;

   // State cleared by power-on reset only.
   typedef struct packed {
      logic        x_en;
      logic        x_xtal;
      logic        x_o32;
      logic        x_o1;
      logic [2:0]  x_start;
      logic [15:0] x_cnt;
      logic        x_rdy;
      logic        x_in_ovr;
      logic        x_out_ovr;
      logic        x_o32_q;
      logic        x_o1_q;
      logic        ulp_on;
   } ocl_persist_t;

endpackage : ocl_pkg

//--- ocl_tb.sv
`timescale 1ns/100ps
`include "ocl_params.svh"
// ============================================================
// Self-checking bench for the oscillator control block.
module testbench;
   import ocl_pkg::*;
   localparam logic [4:0] FTRIM = 5'h15;
   logic        clk, reset, por, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        rerr, mp_request, int_request, gpio, pin_out, irq_o;
   ocl_sleep_t  sleep_mode;
   logic        mp_run_o, mp_xtal_o, mp_amp_auto_o, mp_clk_ok_o;
   logic        mp_in_ovr_o, mp_out_ovr_o, ext_run_o, ext_xtal_o;
   logic        ext_in_ovr_o, ext_out_ovr_o, ext_32k_o, ext_1k_o;
   logic        int_run_o, int_32k_o, int_1k_o, ulp_32k_o, ulp_1k_o;
   logic [2:0]  mp_gain_o;
   logic [6:0]  int_trim_o;
   logic [4:0]  ulp_trim_o;
   int          failures, n_checks, k;
   logic [31:0] ctl;
   logic        sr, od, st, rq;

   ocl_top #(.INT_START_CYC(16'h0004)) dut_u (
      .clk, .reset, .por, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleep_mode, .mp_request, .int_request,
      .factory_trim(FTRIM), .mp_run_o, .mp_xtal_o, .mp_gain_o,
      .mp_amp_auto_o, .mp_in_ovr_o, .mp_out_ovr_o, .mp_clk_ok_o,
      .ext_run_o, .ext_xtal_o, .ext_in_ovr_o, .ext_out_ovr_o, .ext_32k_o,
      .ext_1k_o, .int_run_o, .int_trim_o, .int_32k_o, .int_1k_o,
      .ulp_32k_o, .ulp_1k_o, .ulp_trim_o, .irq_o);
   ocl_pin_model pin_u (.clk, .in_ovr(mp_in_ovr_o), .out_ovr(mp_out_ovr_o),
      .gpio_out(gpio), .pin_out);

   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Prints the counts and the verdict, then stops.
   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // Compares a result and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data and error are taken at the pready edge.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         test_done();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Polls the status word until the given ready bit is seen.
   task automatic wait_stat(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, `OCL_ADDR_STATUS, 32'h0);
         n++;
      end while (rdat[b] !== 1'b1 && n < 100);
      if (rdat[b] !== 1'b1) begin
         failures++;
         test_done();
      end
   endtask : wait_stat

   // Main sequence.
   initial begin
      {reset, por} = 2'b11;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {mp_request, int_request, failures, n_checks} = '0;
      sleep_mode = OCL_ACTIVE;
      gpio = 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      por   <= 1'b0;
      repeat (2) @(posedge clk);
      chk({mp_run_o, mp_in_ovr_o, mp_out_ovr_o}, 0);
      chk({ext_run_o, ext_in_ovr_o, ext_out_ovr_o}, 0);
      chk({ulp_32k_o, ulp_1k_o}, 2'b11);
      chk(int_run_o, 0);
      apb(1'b0, `OCL_ADDR_ULP, 32'h0);
      chk(rdat, FTRIM);
      $display("test reset done");
      apb(1'b1, `OCL_ADDR_IE_SET, 32'h1);
      apb(1'b1, `OCL_ADDR_MP, 32'h3B06);
      repeat (2) @(posedge clk);
      chk({mp_run_o, mp_in_ovr_o, mp_out_ovr_o}, 3'b111);
      chk(mp_gain_o, 3);
      chk(mp_amp_auto_o, 1);
      chk(mp_clk_ok_o, 0);
      wait_stat(0);
      repeat (2) @(posedge clk);
      chk(mp_clk_ok_o, 1);
      chk(irq_o, 1);
      apb(1'b1, `OCL_ADDR_FLAG, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq_o, 0);
      apb(1'b1, `OCL_ADDR_MP, 32'h2);
      repeat (2) @(posedge clk);
      chk({mp_in_ovr_o, mp_out_ovr_o, mp_xtal_o}, 3'b100);
      chk(pin_out, gpio);
      $display("test multipurpose done");
      for (k = 0; k < 16; k++) begin
         {sr, od, st, rq} = 4'(k);
         ctl = 32'h6 | (32'(sr) << 6) | (32'(od) << 7);
         sleep_mode <= OCL_IDLE;
         mp_request <= 1'b1;
         apb(1'b1, `OCL_ADDR_MP, ctl);
         wait_stat(0);
         sleep_mode <= st ? OCL_STANDBY : OCL_IDLE;
         mp_request <= rq;
         repeat (4) @(posedge clk);
         chk(mp_run_o, st ? sr & (!od | rq) : (!od | rq));
         apb(1'b0, `OCL_ADDR_STATUS, 32'h0);
         if (!mp_run_o) chk(rdat[0], 0);
      end
      sleep_mode <= OCL_ACTIVE;
      apb(1'b1, `OCL_ADDR_MP, 32'h0);
      $display("test sleep done");
      apb(1'b1, `OCL_ADDR_EXT, 32'h1E);
      wait_stat(1);
      repeat (2) @(posedge clk);
      chk({ext_32k_o, ext_1k_o}, 2'b11);
      chk({ext_in_ovr_o, ext_out_ovr_o}, 2'b11);
      chk(ext_xtal_o, 1);
      sleep_mode <= OCL_STANDBY;
      repeat (4) @(posedge clk);
      chk(ext_run_o, 1);
      sleep_mode <= OCL_ACTIVE;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      chk(ext_run_o, 1);
      chk(mp_run_o, 0);
      apb(1'b0, `OCL_ADDR_FLAG, 32'h0);
      chk(rdat[1], 0);
      apb(1'b1, `OCL_ADDR_EXT, 32'h1C);
      repeat (2) @(posedge clk);
      chk(ext_run_o, 0);
      apb(1'b0, `OCL_ADDR_STATUS, 32'h0);
      chk(rdat[1], 0);
      apb(1'b1, `OCL_ADDR_EXT, 32'h18);
      apb(1'b1, `OCL_ADDR_EXT, 32'h1A);
      wait_stat(1);
      repeat (2) @(posedge clk);
      chk({ext_in_ovr_o, ext_out_ovr_o}, 2'b10);
      chk({ext_32k_o, ext_1k_o}, 2'b00);
      apb(1'b0, `OCL_ADDR_FLAG, 32'h0);
      chk(rdat[1], 1);
      $display("test slow external done");
      apb(1'b1, `OCL_ADDR_INT, 32'h0005_0006);
      chk(int_trim_o, 0);
      wait_stat(2);
      repeat (2) @(posedge clk);
      chk(int_trim_o, 5);
      chk({int_run_o, int_32k_o, int_1k_o}, 3'b110);
      apb(1'b1, `OCL_ADDR_ULP, 32'h3);
      repeat (2) @(posedge clk);
      chk(ulp_trim_o, 3);
      apb(1'b0, 12'h020, 32'h0);
      chk(rdat, 0);
      chk(rerr, 1);
      $display("test internal and trim done");
      test_done();
   end
endmodule : testbench

//--- ocl_top.sv
`timescale 1ns/100ps
`include "ocl_params.svh"

// Operation
// R1: Multipurpose oscillator off after reset, pins free.
// R2: Crystal mode takes both pins, clock input one.
// R3: Enable bit starts it, select picks crystal.
// R4: Software sets gain to suit the crystal.
// R5: Auto amplitude control active in crystal mode.
// R6: Sleep run follows enable, standby-run, on-request.
// R7: Output masked during selected start-up time.
// R8: Ready flag set when start-up time expires.
// R9: Ready rising edge raises enabled interrupt.
// R10: Software waits for ready before standby.
// R11: Slow external oscillator off at power-on.
// R12: Slow crystal takes both pins, clock one.
// R13: Slow enable starts it, select picks crystal.
// R14: Software disables slow oscillator changing enable only.
// R15: Slow external oscillator runs in every sleep.
// R16: Slow external output masked, then ready set.
// R17: Slow ready rising edge raises enabled interrupt.
// R18: Slow external oscillator survives non-power-on resets.
// R19: Slow 32k and 1k outputs, crystal only.
// R20: Internal oscillator runs while enabled, gated outputs. The code also needs on-request clear or a request, and standby-run in standby.
// R21: Internal trim takes effect when ready rises.
// R22: Low-power oscillator always runs, outputs always on.
// R23: Low-power trim loaded at start, writable.
// R24: Ready clears when its oscillator stops.
module ocl_top #(
   parameter logic [15:0] INT_START_CYC = `OCL_INT_START_CYC
) (
   // Clock and resets.
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             por,
   // APB slave.
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Power manager and clock requests.
   input  wire ocl_pkg::ocl_sleep_t sleep_mode,
   input  wire logic             mp_request,
   input  wire logic             int_request,
   input  wire logic [4:0]       factory_trim,
   // Multipurpose oscillator.
   output logic                  mp_run_o,
   output logic                  mp_xtal_o,
   output logic      [2:0]       mp_gain_o,
   output logic                  mp_amp_auto_o,
   output logic                  mp_in_ovr_o,
   output logic                  mp_out_ovr_o,
   output logic                  mp_clk_ok_o,
   // Slow external oscillator.
   output logic                  ext_run_o,
   output logic                  ext_xtal_o,
   output logic                  ext_in_ovr_o,
   output logic                  ext_out_ovr_o,
   output logic                  ext_32k_o,
   output logic                  ext_1k_o,
   // Internal and low-power oscillators.
   output logic                  int_run_o,
   output logic      [6:0]       int_trim_o,
   output logic                  int_32k_o,
   output logic                  int_1k_o,
   output logic                  ulp_32k_o,
   output logic                  ulp_1k_o,
   output logic      [4:0]       ulp_trim_o,
   // Interrupt request.
   output logic                  irq_o
);
   import ocl_pkg::*;

   ocl_state_t   st_q, st_d;
   ocl_persist_t ps_q, ps_d;

   logic        access;
   logic        commit;
   logic        wr;
   logic        mp_run;
   logic        int_run;
   logic        int_restart;
   logic [16:0] mp_next;
   logic [16:0] int_next;
   logic [16:0] ext_next;
   logic [2:0]  rise;
   logic [31:0] rdata;
   logic        mapped;

   // ============================================================
   // Helper functions.

   // Start-up limit: a select of n gives 2**n cycles.
   function automatic logic [15:0] ocl_limit(input logic [3:0] sel);
      ocl_limit = ~(`OCL_CNT_FULL << sel);
   endfunction : ocl_limit

   // One start-up timer step, returns ready and count.
   function automatic logic [16:0] ocl_startup(
      input logic        run,
      input logic        rdy,
      input logic [15:0] cnt,
      input logic [15:0] lim
   );
      if (!run) begin
         ocl_startup = {1'b0, 16'h0000};
      end else if (rdy) begin
         ocl_startup = {1'b1, cnt};
      end else if (cnt >= lim) begin
         ocl_startup = {1'b1, cnt};
      end else begin
         ocl_startup = {1'b0, 16'(cnt + 16'h0001)};
      end
   endfunction : ocl_startup

   // Run decision from enable, standby-run and on-request.
   function automatic logic ocl_runs(
      input logic       en,
      input logic       sr,
      input logic       od,
      input logic       req,
      input ocl_sleep_t mode
   );
      if (!en) begin
         ocl_runs = 1'b0;
      end else if (mode == OCL_STANDBY) begin
         ocl_runs = sr && (!od || req);
      end else begin
         ocl_runs = !od || req;
      end
   endfunction : ocl_runs

   // Address decode used by the write paths.
   function automatic logic ocl_hit(
      input logic [11:0] a,
      input logic [11:0] reg_addr
   );
      ocl_hit = (a == reg_addr);
   endfunction : ocl_hit

   // ============================================================
   // Bus qualifiers; a transfer completes in its second access cycle.
   assign access = psel && penable;
   assign commit = access && st_q.pready;
   assign wr     = commit && pwrite;

   // ============================================================
   // Run decisions and start-up timers.
   always_comb begin
      mp_run  = ocl_runs(st_q.mp_en, st_q.mp_sr, st_q.mp_od,
                         mp_request, sleep_mode); // [R6]
      int_run = ocl_runs(st_q.int_en, st_q.int_sr, st_q.int_od,
                         int_request, sleep_mode); // [R20]
      // A new trim restarts the internal start-up so ready rises again.
      int_restart = wr && ocl_hit(paddr, `OCL_ADDR_INT) &&
         (pwdata[`OCL_F_ITR_HI:`OCL_F_ITR_LO] != st_q.int_trim); // [R21]
      mp_next  = ocl_startup(st_q.mp_run, st_q.mp_rdy, st_q.mp_cnt,
                             ocl_limit(st_q.mp_start)); // [R7] [R8] [R24]
      int_next = ocl_startup(st_q.int_run && !int_restart, st_q.int_rdy,
                             st_q.int_cnt, INT_START_CYC); // [R24]
      ext_next = ocl_startup(ps_q.x_en, ps_q.x_rdy, ps_q.x_cnt,
                             ocl_limit({1'b0, ps_q.x_start})); // [R16]
      rise[`OCL_B_MP]  = mp_next[16] && !st_q.mp_rdy;
      rise[`OCL_B_EXT] = ps_q.x_rdy && !st_q.ext_rdy_prev && !st_q.trim_load;
      rise[`OCL_B_INT] = int_next[16] && !st_q.int_rdy;
   end

   // ============================================================
   // Read mux and decode.
   always_comb begin
      rdata  = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         `OCL_ADDR_MP: begin
            rdata[`OCL_F_EN]   = st_q.mp_en;
            rdata[`OCL_F_XTAL] = st_q.mp_xtal;
            rdata[`OCL_F_SR]   = st_q.mp_sr;
            rdata[`OCL_F_OD]   = st_q.mp_od;
            rdata[`OCL_F_GAIN_HI:`OCL_F_GAIN_LO] = st_q.mp_gain;
            rdata[`OCL_F_AMP]  = st_q.mp_amp;
            rdata[`OCL_F_MST_HI:`OCL_F_MST_LO] = st_q.mp_start;
         end
         `OCL_ADDR_EXT: begin
            rdata[`OCL_F_EN]   = ps_q.x_en;
            rdata[`OCL_F_XTAL] = ps_q.x_xtal;
            rdata[`OCL_F_O32]  = ps_q.x_o32;
            rdata[`OCL_F_O1]   = ps_q.x_o1;
            rdata[`OCL_F_XST_HI:`OCL_F_XST_LO] = ps_q.x_start;
         end
         `OCL_ADDR_INT: begin
            rdata[`OCL_F_EN]   = st_q.int_en;
            rdata[`OCL_F_XTAL] = st_q.int_o32;
            rdata[`OCL_F_O32]  = st_q.int_o1;
            rdata[`OCL_F_SR]   = st_q.int_sr;
            rdata[`OCL_F_OD]   = st_q.int_od;
            rdata[`OCL_F_ITR_HI:`OCL_F_ITR_LO] = st_q.int_trim;
         end
         `OCL_ADDR_ULP: begin
            rdata[`OCL_F_UTR_HI:`OCL_F_UTR_LO] = st_q.ulp_trim;
         end
         `OCL_ADDR_STATUS: begin
            rdata[`OCL_B_MP]  = st_q.mp_rdy; // [R8]
            rdata[`OCL_B_EXT] = ps_q.x_rdy; // [R16]
            rdata[`OCL_B_INT] = st_q.int_rdy;
         end
         `OCL_ADDR_IE_SET, `OCL_ADDR_IE_CLR: begin
            rdata[2:0] = st_q.ie;
         end
         `OCL_ADDR_FLAG: begin
            rdata[2:0] = st_q.flag;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ============================================================
   // Next state of the reset-cleared part.
   always_comb begin
      st_d = st_q;
      // Bus answer: ready one cycle into the access phase.
      st_d.pready  = access && !st_q.pready;
      st_d.pslverr = access && !st_q.pready && !mapped;
      st_d.prdata  = (access && !st_q.pready && !pwrite && mapped) ?
                     rdata : 32'h0000_0000;
      // Factory trim is taken once just after reset release.
      if (st_q.trim_load) begin
         st_d.ulp_trim  = factory_trim; // [R23]
         st_d.trim_load = 1'b0;
      end
      if (wr && ocl_hit(paddr, `OCL_ADDR_MP)) begin
         st_d.mp_en    = pwdata[`OCL_F_EN]; // [R3]
         st_d.mp_xtal  = pwdata[`OCL_F_XTAL]; // [R3]
         st_d.mp_sr    = pwdata[`OCL_F_SR];
         st_d.mp_od    = pwdata[`OCL_F_OD];
         st_d.mp_gain  = pwdata[`OCL_F_GAIN_HI:`OCL_F_GAIN_LO];
         st_d.mp_amp   = pwdata[`OCL_F_AMP];
         st_d.mp_start = pwdata[`OCL_F_MST_HI:`OCL_F_MST_LO];
      end
      if (wr && ocl_hit(paddr, `OCL_ADDR_INT)) begin
         st_d.int_en   = pwdata[`OCL_F_EN];
         st_d.int_o32  = pwdata[`OCL_F_XTAL];
         st_d.int_o1   = pwdata[`OCL_F_O32];
         st_d.int_sr   = pwdata[`OCL_F_SR];
         st_d.int_od   = pwdata[`OCL_F_OD];
         st_d.int_trim = pwdata[`OCL_F_ITR_HI:`OCL_F_ITR_LO];
      end
      if (wr && ocl_hit(paddr, `OCL_ADDR_ULP)) begin
         st_d.ulp_trim = pwdata[`OCL_F_UTR_HI:`OCL_F_UTR_LO]; // [R23]
      end
      if (wr && ocl_hit(paddr, `OCL_ADDR_IE_SET)) begin
         st_d.ie = st_q.ie | pwdata[2:0];
      end
      if (wr && ocl_hit(paddr, `OCL_ADDR_IE_CLR)) begin
         st_d.ie = st_q.ie & ~pwdata[2:0];
      end
      // Flags: write one clears, a rising ready in the same cycle wins.
      if (wr && ocl_hit(paddr, `OCL_ADDR_FLAG)) begin
         st_d.flag = st_q.flag & ~pwdata[2:0];
      end
      st_d.flag = st_d.flag | rise; // [R9] [R17]
      st_d.irq  = |(st_d.flag & st_d.ie); // [R9] [R17]
      // Multipurpose oscillator outputs.
      {st_d.mp_rdy, st_d.mp_cnt} = mp_next;
      st_d.mp_run     = mp_run;
      st_d.mp_in_ovr  = st_q.mp_en; // [R1] [R2]
      st_d.mp_out_ovr = st_q.mp_en && st_q.mp_xtal; // [R2]
      st_d.mp_clk_ok  = st_q.mp_run && st_q.mp_rdy; // [R7]
      // Internal oscillator: trim is committed as ready rises.
      {st_d.int_rdy, st_d.int_cnt} = int_next;
      st_d.int_run = int_run;
      if (rise[`OCL_B_INT]) begin
         st_d.int_trim_act = st_q.int_trim; // [R21]
      end
      st_d.int_o32_q = st_q.int_rdy && st_q.int_o32; // [R20]
      st_d.int_o1_q  = st_q.int_rdy && st_q.int_o1; // [R20]
      st_d.ext_rdy_prev = ps_q.x_rdy;
   end

   // ============================================================
   // Next state of the part that only power-on reset clears.
   always_comb begin
      ps_d = ps_q;
      if (wr && ocl_hit(paddr, `OCL_ADDR_EXT)) begin
         // Each field is taken as written; disabling is left to software.
         ps_d.x_en    = pwdata[`OCL_F_EN]; // [R13] [R14]
         ps_d.x_xtal  = pwdata[`OCL_F_XTAL]; // [R13]
         ps_d.x_o32   = pwdata[`OCL_F_O32];
         ps_d.x_o1    = pwdata[`OCL_F_O1];
         ps_d.x_start = pwdata[`OCL_F_XST_HI:`OCL_F_XST_LO];
      end
      // Runs whenever enabled, whatever the sleep mode.
      {ps_d.x_rdy, ps_d.x_cnt} = ext_next; // [R15] [R16]
      ps_d.x_in_ovr  = ps_q.x_en; // [R11] [R12]
      ps_d.x_out_ovr = ps_q.x_en && ps_q.x_xtal; // [R12]
      ps_d.x_o32_q = ps_q.x_rdy && ps_q.x_xtal && ps_q.x_o32; // [R19]
      ps_d.x_o1_q  = ps_q.x_rdy && ps_q.x_xtal && ps_q.x_o1; // [R19]
      ps_d.ulp_on  = 1'b1; // [R22]
   end

   // ============================================================
   // Registers cleared by any reset.
   always_ff @(posedge clk or posedge reset or posedge por) begin
      if (reset || por) begin
         st_q           <= '0;
         st_q.mp_od     <= `OCL_RST_OD;
         st_q.int_od    <= `OCL_RST_OD;
         st_q.int_trim  <= `OCL_RST_TRIM;
         st_q.trim_load <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Registers that survive every reset but power-on.
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         ps_q <= '0; // [R11] [R18]
      end else begin
         ps_q <= ps_d;
      end
   end

   // ============================================================
   // Outputs, each straight from a flip-flop.
   assign prdata        = st_q.prdata;
   assign pready        = st_q.pready;
   assign pslverr       = st_q.pslverr;
   assign mp_run_o      = st_q.mp_run;
   assign mp_xtal_o     = st_q.mp_xtal;
   assign mp_gain_o     = st_q.mp_gain; // [R4]
   assign mp_amp_auto_o = st_q.mp_amp; // [R5]
   assign mp_in_ovr_o   = st_q.mp_in_ovr;
   assign mp_out_ovr_o  = st_q.mp_out_ovr;
   assign mp_clk_ok_o   = st_q.mp_clk_ok;
   assign ext_run_o     = ps_q.x_en;
   assign ext_xtal_o    = ps_q.x_xtal;
   assign ext_in_ovr_o  = ps_q.x_in_ovr;
   assign ext_out_ovr_o = ps_q.x_out_ovr;
   assign ext_32k_o     = ps_q.x_o32_q;
   assign ext_1k_o      = ps_q.x_o1_q;
   assign int_run_o     = st_q.int_run;
   assign int_trim_o    = st_q.int_trim_act;
   assign int_32k_o     = st_q.int_o32_q;
   assign int_1k_o      = st_q.int_o1_q;
   assign ulp_32k_o     = ps_q.ulp_on;
   assign ulp_1k_o      = ps_q.ulp_on;
   assign ulp_trim_o    = st_q.ulp_trim;
   assign irq_o         = st_q.irq;

   // ============================================================
   // Assertions and covers.
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || por);

   AST_MP_PINS_FREE: assert property ( // [R1]
      !st_q.mp_en |=> !mp_in_ovr_o && !mp_out_ovr_o)
      else $error("pins held while oscillator disabled");

   AST_MP_EXTCLK_PINS: assert property ( // [R2]
      wr && paddr == `OCL_ADDR_MP && pwdata[`OCL_F_EN] &&
      !pwdata[`OCL_F_XTAL] |=> ##1 mp_in_ovr_o && !mp_out_ovr_o)
      else $error("clock input mode pin takeover wrong");

   AST_MP_STANDBY_STOP: assert property ( // [R6]
      (sleep_mode == OCL_STANDBY && !st_q.mp_sr) [*2] |-> !mp_run_o)
      else $error("oscillator ran in standby without standby-run");

   AST_MP_MASK: assert property ( // [R7]
      mp_clk_ok_o |-> $past(st_q.mp_rdy) && $past(st_q.mp_run))
      else $error("output passed before start-up ended");

   AST_MP_READY_TIME: assert property ( // [R8]
      $rose(mp_run_o) && st_q.mp_start == 4'h0 |-> ##[1:2] st_q.mp_rdy)
      else $error("ready late for shortest start-up");

   AST_MP_IRQ: assert property ( // [R9]
      $rose(st_q.mp_rdy) && st_q.ie[`OCL_B_MP] |-> irq_o)
      else $error("ready rise gave no interrupt");

   AST_EXT_SLEEP_RUN: assert property ( // [R15]
      ps_q.x_en && ps_q.x_rdy && sleep_mode == OCL_STANDBY |=> ps_q.x_rdy)
      else $error("slow oscillator stopped in sleep");

   AST_EXT_OUT_XTAL: assert property ( // [R19]
      ext_32k_o || ext_1k_o |-> $past(ps_q.x_xtal) && $past(ps_q.x_rdy))
      else $error("slow outputs active outside crystal mode");

   AST_INT_TRIM: assert property ( // [R21]
      $changed(int_trim_o) |-> $rose(st_q.int_rdy))
      else $error("trim applied without ready rise");

   AST_RDY_CLEAR: assert property ( // [R24]
      !st_q.mp_run |=> !st_q.mp_rdy)
      else $error("ready kept while oscillator stopped");

   COV_MP_READY:  cover property ($rose(st_q.mp_rdy));
   COV_EXT_READY: cover property ($rose(ps_q.x_rdy));
   COV_INT_TRIM:  cover property ($changed(int_trim_o));
   COV_IRQ:       cover property ($rose(irq_o));

endmodule : ocl_top
